// *** inc/oad_defs.svh ***
`ifndef OAD_DEFS_SVH
`define OAD_DEFS_SVH

// short-direct window, byte and word forms
`define OAD_SADDR_BASE 16'hfe20
`define OAD_SADDR_LAST 16'hff1f

// peripheral-register page and the hole the operand forms cannot reach
`define OAD_SFR_BASE 16'hff00
`define OAD_SFR_HOLE_LO 16'hffd0
`define OAD_SFR_HOLE_HI 16'hffdf

// far-call and call-table targets
`define OAD_FAR_BASE 16'h0800
`define OAD_FAR_LAST 16'h0fff
`define OAD_CALLT_BASE 16'h0040
`define OAD_CALLT_LAST 16'h007f

// accumulator register codes inside a bank
`define OAD_ACC_LO_CODE 3'h0
`define OAD_ACC_HI_CODE 3'h1

// reset values
`define OAD_RST_ADDR 16'h0000
`define OAD_RST_MASK 8'h00
`define OAD_RST_INDEX 5'h00
`define OAD_RST_FLAG 1'b0

`endif

// *** inc/oad_pkg.sv ***
package oad_pkg;

    // operand form presented with each decode request
    typedef enum logic [2:0] {
        OAD_FORM_SADDR  = 3'b000,
        OAD_FORM_SADDRP = 3'b001,
        OAD_FORM_ABS    = 3'b010,
        OAD_FORM_FAR    = 3'b011,
        OAD_FORM_CALLT  = 3'b100,
        OAD_FORM_SFR    = 3'b101,
        OAD_FORM_SFRP   = 3'b110,
        OAD_FORM_REL    = 3'b111
    } oad_form_t;

    // what an instruction does to one status flag
    typedef enum logic [2:0] {
        OAD_FLAG_KEEP    = 3'b000,
        OAD_FLAG_CLEAR   = 3'b001,
        OAD_FLAG_SET     = 3'b010,
        OAD_FLAG_RESULT  = 3'b011,
        OAD_FLAG_RESTORE = 3'b100
    } oad_flag_act_t;

    // reason an address was refused
    typedef enum logic [1:0] {
        OAD_FAULT_NONE     = 2'b00,
        OAD_FAULT_ODD      = 2'b01,
        OAD_FAULT_HOLE     = 2'b10,
        OAD_FAULT_NOT_WORD = 2'b11
    } oad_fault_t;

    // whole registered state of the decoder
    typedef struct packed {
        logic [15:0] ea;
        logic ea_valid;
        oad_fault_t fault;
        logic [4:0] reg_index;
        logic [4:0] pair_lo_index;
        logic [4:0] pair_hi_index;
        logic [4:0] acc_lo_index;
        logic [4:0] acc_hi_index;
        logic [4:0] acc8_index;
        logic [7:0] bit_mask;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } oad_state_t;

endpackage : oad_pkg

// *** design/oad_flag_cell.sv ***
`timescale 1ns/1ps
`default_nettype none

module oad_flag_cell
    import oad_pkg::*;
(
    // control
    input wire oad_flag_act_t i_act,
    // flag sources
    input wire logic i_current,
    input wire logic i_result,
    input wire logic i_saved,
    // next flag value
    output logic o_next
);

    // one flag per instance so zero, half-carry and carry share the same update law
    always_comb
    begin
        unique case (i_act)
            OAD_FLAG_KEEP:    o_next = i_current;
            OAD_FLAG_CLEAR:   o_next = 1'b0;
            OAD_FLAG_SET:     o_next = 1'b1;
            OAD_FLAG_RESULT:  o_next = i_result;
            OAD_FLAG_RESTORE: o_next = i_saved;
            // unused codes hold the flag rather than corrupt it
            default:          o_next = i_current;
        endcase
    end

endmodule : oad_flag_cell

`default_nettype wire

// *** design/oad_operand_decoder.sv ***
// Behaviour
// - short-direct byte operand maps to address window FE20H through FF1FH.
// - short-direct word operand only at even addresses, low byte of pair.
// - absolute operand spans 0000H-FFFFH; word transfers need an even address.
// - far-call target always lands between 0800H and 0FFFH.
// - call-table pointer becomes even table address within 0040H to 007FH.
// - peripheral-register operands never reach FFD0H through FFDFH.
// - peripheral word access only to word-capable registers at even addresses.
// - register codes 0 to 7 select X, A, C, B, E, D, L, H.
// - pair codes 0 to 3 select AX, BC, DE, HL.
// - A is byte accumulator; AX is word accumulator, X low, A high.
// - relative offset is signed 8-bit, added to program counter.
// - bit-position operand is 3 bits choosing one of eight bits.
// - flags are kept, forced, or taken from the result per instruction.
// - flags marked for restoration reload the previously saved value.
`timescale 1ns/1ps
`default_nettype none

`include "oad_defs.svh"

module oad_operand_decoder
    import oad_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,

    // decode request from fetch
    input wire logic i_valid,
    input wire oad_form_t i_form,
    input wire logic i_word,
    input wire logic [15:0] i_operand,
    input wire logic [15:0] i_pc,
    input wire logic i_sfr_word_ok,

    // register, pair and bit fields
    input wire logic [2:0] i_reg_code,
    input wire logic [1:0] i_pair_code,
    input wire logic [2:0] i_bit_sel,
    input wire logic [1:0] i_bank_select_bits,

    // flag update request
    input wire logic i_flag_valid,
    input wire oad_flag_act_t i_zero_act,
    input wire oad_flag_act_t i_half_carry_act,
    input wire oad_flag_act_t i_carry_act,
    input wire logic i_zero_result,
    input wire logic i_half_carry_result,
    input wire logic i_carry_result,
    input wire logic i_zero_saved,
    input wire logic i_half_carry_saved,
    input wire logic i_carry_saved,

    // effective address
    output logic [15:0] o_ea,
    output logic o_ea_valid,
    output logic o_fault,
    output logic [1:0] o_fault_cause,

    // register file selects
    output logic [4:0] o_reg_index,
    output logic [4:0] o_pair_lo_index,
    output logic [4:0] o_pair_hi_index,
    output logic [4:0] o_acc8_index,
    output logic [4:0] o_acc_lo_index,
    output logic [4:0] o_acc_hi_index,
    output logic [7:0] o_bit_mask,

    // status flags
    output logic o_zero_flag,
    output logic o_half_carry_flag,
    output logic o_carry_flag
);

    oad_state_t state_q;
    oad_state_t state_d;

    // combinational address terms
    logic [15:0] saddr_ea;
    logic [15:0] sfr_ea;
    logic [15:0] far_ea;
    logic [15:0] callt_ea;
    logic [15:0] rel_ea;
    logic [15:0] rel_offset;
    logic sfr_in_hole;
    logic [15:0] form_ea;
    oad_fault_t form_fault;

    // flag cell outputs
    logic zero_next;
    logic half_carry_next;
    logic carry_next;

    // the address terms below add or OR a field onto a base; that only stays inside
    // the window when it matches the field's span and, for an OR, the base is aligned to it, so refuse other maps
    if ((`OAD_SADDR_BASE + 16'h00ff) != `OAD_SADDR_LAST)
    begin : g_saddr_span_check
        $error("short-direct window must span exactly 256 bytes");
    end

    if (((`OAD_FAR_BASE & 16'h07ff) != 16'h0000) ||
        ((`OAD_FAR_BASE | 16'h07ff) != `OAD_FAR_LAST))
    begin : g_far_page_check
        $error("far-call page must be one aligned 2 KB block");
    end

    if (((`OAD_CALLT_BASE & 16'h003f) != 16'h0000) ||
        ((`OAD_CALLT_BASE | 16'h003f) != `OAD_CALLT_LAST))
    begin : g_callt_table_check
        $error("call table must be one aligned 64-byte block");
    end

    // the hole test works on formed addresses, so the hole must lie in the page
    if (((`OAD_SFR_BASE & 16'h00ff) != 16'h0000) ||
        ((`OAD_SFR_HOLE_LO & 16'hff00) != `OAD_SFR_BASE) ||
        ((`OAD_SFR_HOLE_HI & 16'hff00) != `OAD_SFR_BASE))
    begin : g_sfr_hole_check
        $error("peripheral hole must sit inside an aligned peripheral page");
    end

    // short-direct: a plain offset from the window base, so 00H..FFH covers it exactly
    assign saddr_ea = `OAD_SADDR_BASE + {8'h00, i_operand[7:0]};

    // peripheral page sits on the top 256 bytes
    assign sfr_ea = `OAD_SFR_BASE | {8'h00, i_operand[7:0]};

    // hole check on the formed address, not the raw code, to stay tied to the map
    assign sfr_in_hole = (sfr_ea >= `OAD_SFR_HOLE_LO) && (sfr_ea <= `OAD_SFR_HOLE_HI);

    // far call: only 11 bits are taken, so no operand can leave the 2 KB page
    assign far_ea = `OAD_FAR_BASE | {5'h00, i_operand[10:0]};

    // call table: 5-bit pointer doubled, always even
    assign callt_ea = `OAD_CALLT_BASE | {10'h000, i_operand[4:0], 1'b0};

    // relative branch: sign-extend the displacement, wrap in 16 bits
    assign rel_offset = {{8{i_operand[7]}}, i_operand[7:0]};
    assign rel_ea = i_pc + rel_offset;

    // address and refusal per operand form
    always_comb
    begin
        form_ea = i_operand;
        form_fault = OAD_FAULT_NONE;
        unique case (i_form)
            OAD_FORM_SADDR:
            begin
                form_ea = saddr_ea;
            end
            OAD_FORM_SADDRP:
            begin
                form_ea = saddr_ea;
                // the odd byte of a pair is never a valid word start
                if (saddr_ea[0])
                begin
                    form_fault = OAD_FAULT_ODD;
                end
            end
            OAD_FORM_ABS:
            begin
                form_ea = i_operand;
                if (i_word && i_operand[0])
                begin
                    form_fault = OAD_FAULT_ODD;
                end
            end
            OAD_FORM_FAR:
            begin
                form_ea = far_ea;
            end
            OAD_FORM_CALLT:
            begin
                form_ea = callt_ea;
            end
            OAD_FORM_SFR:
            begin
                form_ea = sfr_ea;
                if (sfr_in_hole)
                begin
                    form_fault = OAD_FAULT_HOLE;
                end
            end
            OAD_FORM_SFRP:
            begin
                form_ea = sfr_ea;
                // hole outranks alignment: the address is unreachable either way
                if (sfr_in_hole)
                begin
                    form_fault = OAD_FAULT_HOLE;
                end
                else if (sfr_ea[0])
                begin
                    form_fault = OAD_FAULT_ODD;
                end
                else if (!i_sfr_word_ok)
                begin
                    form_fault = OAD_FAULT_NOT_WORD;
                end
            end
            OAD_FORM_REL:
            begin
                form_ea = rel_ea;
            end
        endcase
    end

    // one flag cell per status flag
    oad_flag_cell u_zero_cell (
        .i_act(i_zero_act),
        .i_current(state_q.zero_flag),
        .i_result(i_zero_result),
        .i_saved(i_zero_saved),
        .o_next(zero_next)
    );

    oad_flag_cell u_half_carry_cell (
        .i_act(i_half_carry_act),
        .i_current(state_q.half_carry_flag),
        .i_result(i_half_carry_result),
        .i_saved(i_half_carry_saved),
        .o_next(half_carry_next)
    );

    oad_flag_cell u_carry_cell (
        .i_act(i_carry_act),
        .i_current(state_q.carry_flag),
        .i_result(i_carry_result),
        .i_saved(i_carry_saved),
        .o_next(carry_next)
    );

    // next state: decode results load on a request, flags on a flag update
    always_comb
    begin
        state_d = state_q;
        // ea_valid is a one-cycle answer per request
        state_d.ea_valid = 1'b0;

        if (i_valid)
        begin
            state_d.ea_valid = 1'b1;
            state_d.ea = form_ea;
            state_d.fault = form_fault;
            // bank bits form the top of every register index
            state_d.reg_index = {i_bank_select_bits, i_reg_code};
            // pair n is register 2n (low) and 2n+1 (high): AX, BC, DE, HL
            state_d.pair_lo_index = {i_bank_select_bits, i_pair_code, 1'b0};
            state_d.pair_hi_index = {i_bank_select_bits, i_pair_code, 1'b1};
            // accumulators follow the bank too
            state_d.acc8_index = {i_bank_select_bits, `OAD_ACC_HI_CODE};
            state_d.acc_lo_index = {i_bank_select_bits, `OAD_ACC_LO_CODE};
            state_d.acc_hi_index = {i_bank_select_bits, `OAD_ACC_HI_CODE};
            // one-hot so the data path can mask without a decoder of its own
            state_d.bit_mask = 8'h01 << i_bit_sel;
        end

        // flags change only when the executing instruction says so
        if (i_flag_valid)
        begin
            state_d.zero_flag = zero_next;
            state_d.half_carry_flag = half_carry_next;
            state_d.carry_flag = carry_next;
        end
    end

    // single register for the whole state
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_q.ea <= `OAD_RST_ADDR;
            state_q.ea_valid <= 1'b0;
            state_q.fault <= OAD_FAULT_NONE;
            state_q.reg_index <= `OAD_RST_INDEX;
            state_q.pair_lo_index <= `OAD_RST_INDEX;
            state_q.pair_hi_index <= `OAD_RST_INDEX;
            state_q.acc8_index <= `OAD_RST_INDEX;
            state_q.acc_lo_index <= `OAD_RST_INDEX;
            state_q.acc_hi_index <= `OAD_RST_INDEX;
            state_q.bit_mask <= `OAD_RST_MASK;
            state_q.zero_flag <= `OAD_RST_FLAG;
            state_q.half_carry_flag <= `OAD_RST_FLAG;
            state_q.carry_flag <= `OAD_RST_FLAG;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state register
    assign o_ea = state_q.ea;
    assign o_ea_valid = state_q.ea_valid;
    assign o_fault = state_q.ea_valid && (state_q.fault != OAD_FAULT_NONE);
    assign o_fault_cause = state_q.fault;
    assign o_reg_index = state_q.reg_index;
    assign o_pair_lo_index = state_q.pair_lo_index;
    assign o_pair_hi_index = state_q.pair_hi_index;
    assign o_acc8_index = state_q.acc8_index;
    assign o_acc_lo_index = state_q.acc_lo_index;
    assign o_acc_hi_index = state_q.acc_hi_index;
    assign o_bit_mask = state_q.bit_mask;
    assign o_zero_flag = state_q.zero_flag;
    assign o_half_carry_flag = state_q.half_carry_flag;
    assign o_carry_flag = state_q.carry_flag;

endmodule : oad_operand_decoder

`default_nettype wire

// *** tb/oad_operand_decoder_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module oad_operand_decoder_checker
    import oad_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // watched requests
    input wire logic i_valid,
    input wire oad_form_t i_form,
    input wire logic [15:0] i_operand,
    input wire logic [15:0] i_pc,
    input wire logic [2:0] i_bit_sel,
    input wire logic i_flag_valid,
    input wire oad_flag_act_t i_carry_act,
    // watched answers
    input wire logic [15:0] o_ea,
    input wire logic o_ea_valid,
    input wire logic o_fault,
    input wire logic [1:0] o_fault_cause,
    input wire logic [7:0] o_bit_mask,
    input wire logic o_carry_flag
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    logic [15:0] op_q;
    logic [15:0] pc_q;
    // operand copies line up with the one-cycle answer
    always_ff @(posedge i_clk_sys)
    begin
        op_q <= i_operand;
        pc_q <= i_pc;
    end
    AST_SADDR_MAP: assert property (i_valid && i_form == OAD_FORM_SADDR |=>
        o_ea_valid && o_ea == 16'hfe20 + {8'h00, op_q[7:0]}) else $error("saddr map wrong");
    AST_SADDRP_ODD: assert property (i_valid && i_form == OAD_FORM_SADDRP && i_operand[0]
        |=> o_fault && o_fault_cause == 2'h1) else $error("odd saddrp not refused");
    AST_ABS_EA: assert property (i_valid && i_form == OAD_FORM_ABS |=> o_ea == op_q)
        else $error("absolute address wrong");
    AST_FAR_RANGE: assert property (i_valid && i_form == OAD_FORM_FAR |=>
        o_ea == {5'h01, op_q[10:0]}) else $error("far target wrong");
    AST_CALLT_TABLE: assert property (i_valid && i_form == OAD_FORM_CALLT |=>
        o_ea == {10'h001, op_q[4:0], 1'b0}) else $error("call table address wrong");
    AST_SFR_HOLE: assert property (i_valid && (i_form == OAD_FORM_SFR ||
        i_form == OAD_FORM_SFRP) && i_operand[7:4] == 4'hd |=> o_fault && o_fault_cause == 2'h2)
        else $error("hole address not refused");
    AST_REL_TARGET: assert property (i_valid && i_form == OAD_FORM_REL |=>
        o_ea == pc_q + {{8{op_q[7]}}, op_q[7:0]}) else $error("relative target wrong");
    AST_BIT_ONEHOT: assert property (i_valid |=> o_bit_mask == 8'h01 << $past(i_bit_sel))
        else $error("bit mask wrong");
    AST_CARRY_KEEP: assert property (i_flag_valid && i_carry_act == OAD_FLAG_KEEP |=>
        $stable(o_carry_flag)) else $error("kept carry changed");
    AST_CARRY_SET: assert property (i_flag_valid && i_carry_act == OAD_FLAG_SET |=>
        o_carry_flag) else $error("carry not set");
endmodule : oad_operand_decoder_checker
`default_nettype wire

// *** tb/oad_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module oad_fetch_model
    import oad_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // request toward the decoder
    output logic o_valid,
    output oad_form_t o_form,
    output logic o_word,
    output logic [15:0] o_operand,
    output logic [15:0] o_pc,
    output logic o_ok
);
    // quiet request lines from time zero
    initial
    begin
        o_valid = 1'b0;
        o_form = OAD_FORM_SADDR;
        o_word = 1'b0;
        o_operand = 16'h0000;
        o_pc = 16'h0000;
        o_ok = 1'b0;
    end
    // every request is taken at the next edge, so no wait for ready
    task put(input oad_form_t f, input logic w, input logic [15:0] op, pc, input logic ok);
        @(posedge i_clk_sys);
        #1;
        o_valid = 1'b1;
        o_form = f;
        o_word = w;
        o_operand = op;
        o_pc = pc;
        o_ok = ok;
    endtask : put
    // on release the operand and pc lines flip so a stale operand cannot pass unseen
    task stop;
        o_valid = 1'b0;
        o_operand = ~o_operand;
        o_pc = ~o_pc;
    endtask : stop
endmodule : oad_fetch_model
`default_nettype wire

// *** tb/oad_operand_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module oad_operand_decoder_tb_top
    import oad_pkg::*;
;
    logic i_clk_sys, i_rst, i_valid, i_word, i_sfr_word_ok, i_flag_valid;
    oad_form_t i_form;
    logic [15:0] i_operand, i_pc, o_ea;
    logic [2:0] i_reg_code, i_bit_sel;
    logic [1:0] i_pair_code, i_bank_select_bits, o_fault_cause;
    oad_flag_act_t i_zero_act, i_half_carry_act, i_carry_act;
    logic i_zero_result, i_half_carry_result, i_carry_result;
    logic i_zero_saved, i_half_carry_saved, i_carry_saved;
    logic o_ea_valid, o_fault, o_zero_flag, o_half_carry_flag, o_carry_flag;
    logic [4:0] o_reg_index, o_pair_lo_index, o_pair_hi_index;
    logic [4:0] o_acc8_index, o_acc_lo_index, o_acc_hi_index;
    logic [7:0] o_bit_mask;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    oad_operand_decoder oad_operand_decoder_inst (.*);
    oad_fetch_model oad_fetch_model_inst (.i_clk_sys(i_clk_sys), .o_valid(i_valid),
        .o_form(i_form), .o_word(i_word), .o_operand(i_operand), .o_pc(i_pc),
        .o_ok(i_sfr_word_ok));
    task end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one request, answer looked at in its single valid cycle
    task dec(input oad_form_t f, input logic w, input logic [15:0] op, input logic ok,
        input logic [15:0] e, input logic [1:0] c);
        oad_fetch_model_inst.put(f, w, op, 16'h0000, ok);
        @(posedge i_clk_sys);
        #1;
        oad_fetch_model_inst.stop();
        chk("valid", o_ea_valid, 1'b1);
        chk("ea", o_ea, e);
        chk("cause", o_fault_cause, c);
        chk("fault", o_fault, c != 2'h0);
    endtask : dec
    task t_short;
        dec(OAD_FORM_SADDR, 1'b0, 16'h0000, 1'b0, 16'hfe20, 2'h0);
        dec(OAD_FORM_SADDR, 1'b0, 16'h00ff, 1'b0, 16'hff1f, 2'h0);
        dec(OAD_FORM_SADDRP, 1'b0, 16'h00ff, 1'b0, 16'hff1f, 2'h1);
        dec(OAD_FORM_SADDRP, 1'b0, 16'h0010, 1'b0, 16'hfe30, 2'h0);
    endtask : t_short
    task t_abs;
        dec(OAD_FORM_ABS, 1'b0, 16'hffff, 1'b0, 16'hffff, 2'h0);
        dec(OAD_FORM_ABS, 1'b1, 16'hffff, 1'b0, 16'hffff, 2'h1);
        dec(OAD_FORM_ABS, 1'b1, 16'h0000, 1'b0, 16'h0000, 2'h0);
    endtask : t_abs
    // upper operand bits set so a missing mask shows
    task t_calls;
        dec(OAD_FORM_FAR, 1'b0, 16'hf800, 1'b0, 16'h0800, 2'h0);
        dec(OAD_FORM_FAR, 1'b0, 16'hffff, 1'b0, 16'h0fff, 2'h0);
        dec(OAD_FORM_CALLT, 1'b0, 16'hffe0, 1'b0, 16'h0040, 2'h0);
        dec(OAD_FORM_CALLT, 1'b0, 16'h001f, 1'b0, 16'h007e, 2'h0);
    endtask : t_calls
    // hole beats odd beats not word-capable
    task t_sfr;
        dec(OAD_FORM_SFR, 1'b0, 16'h00d0, 1'b0, 16'hffd0, 2'h2);
        dec(OAD_FORM_SFRP, 1'b0, 16'h00df, 1'b1, 16'hffdf, 2'h2);
        dec(OAD_FORM_SFRP, 1'b0, 16'h0021, 1'b1, 16'hff21, 2'h1);
        dec(OAD_FORM_SFRP, 1'b0, 16'h0020, 1'b0, 16'hff20, 2'h3);
        dec(OAD_FORM_SFRP, 1'b0, 16'h00e0, 1'b1, 16'hffe0, 2'h0);
    endtask : t_sfr
    // back to back: backward branch, then a forward one wrapping past ffff
    task t_rel;
        oad_fetch_model_inst.put(OAD_FORM_REL, 1'b0, 16'h0080, 16'h0010, 1'b0);
        oad_fetch_model_inst.put(OAD_FORM_REL, 1'b0, 16'h0020, 16'hfff0, 1'b0);
        chk("rel back", o_ea, 16'hff90);
        @(posedge i_clk_sys);
        #1;
        oad_fetch_model_inst.stop();
        chk("rel wrap", o_ea, 16'h0010);
        chk("rel valid", o_ea_valid, 1'b1);
        @(posedge i_clk_sys);
        #1;
        chk("idle", o_ea_valid, 1'b0);
    endtask : t_rel
    task t_regs;
        int b, r;
        for (b = 0; b < 4; b++)
            for (r = 0; r < 8; r++)
            begin
                i_bank_select_bits = b[1:0];
                i_reg_code = r[2:0];
                i_pair_code = r[1:0];
                i_bit_sel = r[2:0];
                dec(OAD_FORM_SADDR, 1'b0, 16'h0001, 1'b0, 16'hfe21, 2'h0);
                chk("reg", o_reg_index, {b[1:0], r[2:0]});
                chk("pair lo", o_pair_lo_index, {b[1:0], r[1:0], 1'b0});
                chk("pair hi", o_pair_hi_index, {b[1:0], r[1:0], 1'b1});
                chk("acc8", o_acc8_index, {b[1:0], 3'h1});
                chk("acc lo", o_acc_lo_index, {b[1:0], 3'h0});
                chk("acc hi", o_acc_hi_index, {b[1:0], 3'h1});
                chk("mask", o_bit_mask, 8'h01 << r);
            end
    endtask : t_regs
    function automatic logic nf(input logic [2:0] a, input logic cur, res, sav);
        case (a)
            3'h1: return 1'b0;
            3'h2: return 1'b1;
            3'h3: return res;
            3'h4: return sav;
            default: return cur;
        endcase
    endfunction : nf
    // every action code, updates back to back, then a reset mid-run
    task t_flags;
        logic [2:0] s [0:9];
        logic z, h, c;
        int i;
        s = '{3'h1, 3'h2, 3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3, 3'h2};
        z = 1'b0;
        h = 1'b0;
        c = 1'b0;
        i_flag_valid = 1'b1;
        for (i = 0; i < 10; i++)
        begin
            i_zero_act = oad_flag_act_t'(s[i]);
            i_half_carry_act = oad_flag_act_t'(s[i]);
            i_carry_act = oad_flag_act_t'(s[i]);
            {i_zero_result, i_half_carry_result, i_carry_result} = {i[0], ~i[0], i[1]};
            {i_zero_saved, i_half_carry_saved, i_carry_saved} = {~i[1], i[0], 1'b1};
            z = nf(s[i], z, i_zero_result, i_zero_saved);
            h = nf(s[i], h, i_half_carry_result, i_half_carry_saved);
            c = nf(s[i], c, i_carry_result, i_carry_saved);
            @(posedge i_clk_sys);
            #1;
            chk("zero", o_zero_flag, z);
            chk("half", o_half_carry_flag, h);
            chk("carry", o_carry_flag, c);
        end
        i_flag_valid = 1'b0;
        i_rst = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        chk("carry rst", o_carry_flag, 1'b0);
        chk("zero rst", o_zero_flag, 1'b0);
        chk("half rst", o_half_carry_flag, 1'b0);
        chk("ea rst", o_ea, 16'h0000);
        chk("mask rst", o_bit_mask, 8'h00);
        chk("reg rst", o_reg_index, 5'h00);
    endtask : t_flags
    // clock at 40 MHz
    initial
    begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // a hang counts as a mismatch and ends the run
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    initial
    begin
        i_rst = 1'b1;
        i_flag_valid = 1'b0;
        {i_reg_code, i_pair_code, i_bit_sel, i_bank_select_bits} = 10'h000;
        i_zero_act = OAD_FLAG_KEEP;
        i_half_carry_act = OAD_FLAG_KEEP;
        i_carry_act = OAD_FLAG_KEEP;
        {i_zero_result, i_half_carry_result, i_carry_result} = 3'h0;
        {i_zero_saved, i_half_carry_saved, i_carry_saved} = 3'h0;
        repeat (16) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        t_short();
        t_abs();
        t_calls();
        t_sfr();
        t_rel();
        t_regs();
        t_flags();
        dec(OAD_FORM_SADDR, 1'b0, 16'h00ff, 1'b0, 16'hff1f, 2'h0);
        end_sim();
    end
endmodule : oad_operand_decoder_tb_top
bind oad_operand_decoder oad_operand_decoder_checker oad_operand_decoder_checker_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_valid(i_valid), .i_form(i_form),
    .i_operand(i_operand), .i_pc(i_pc), .i_bit_sel(i_bit_sel), .i_flag_valid(i_flag_valid),
    .i_carry_act(i_carry_act), .o_ea(o_ea), .o_ea_valid(o_ea_valid), .o_fault(o_fault),
    .o_fault_cause(o_fault_cause), .o_bit_mask(o_bit_mask), .o_carry_flag(o_carry_flag));
`default_nettype wire
